// *** rtl/sst_defines.svh ***
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define SST_OP_SUB 6'h02
`define SST_OP_SWAP 6'h0e
`define SST_OP_DIR 11'h00c
`define SST_DIR_MIN 3'h5
`define SST_DEST_BIT 7
`define SST_OP_HI 13
`define SST_OP_LO 8
`define SST_DIR_LO 3
`define SST_ADDR_HI 6
`define SST_SEL_HI 2
`define SST_W_RESET 8'h00
`endif

// *** rtl/sst_pkg.sv ***
package sst_pkg;
   // Write-back bundle toward working register, file and direction registers
   typedef struct packed {
      logic w_we;
      logic f_we;
      logic [6:0] f_addr;
      logic dir_we;
      logic [2:0] dir_sel;
      logic [7:0] data;
   } sst_wb_t;
   // Status flag update bundle
   typedef struct packed {
      logic we;
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } sst_flags_t;
   typedef enum logic [1:0] {SST_NONE, SST_SUB, SST_SWAP, SST_DIR} sst_op_t;
endpackage

// *** rtl/sst_exec.sv ***
`timescale 1ns/10ps
`include "sst_defines.svh"
module sst_exec
   import sst_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   input wire logic [7:0] file_rdata,
   output logic [7:0] work_reg,
   output sst_wb_t wb,
   output sst_flags_t flags
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   sst_op_t op;
   logic dest;
   logic [5:0] op_field;
   logic [10:0] dir_field;
   logic [6:0] addr_field;
   logic [2:0] sel_field;
   logic sub_hit;
   logic swap_hit;
   logic dir_hit;
   logic w_write;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [7:0] result;

   // Instruction word fields
   assign op_field = instr[`SST_OP_HI:`SST_OP_LO];
   assign dir_field = instr[`SST_OP_HI:`SST_DIR_LO];
   assign addr_field = instr[`SST_ADDR_HI:0];
   assign sel_field = instr[`SST_SEL_HI:0];
   assign dest = instr[`SST_DEST_BIT];

   // Opcode matches; the legacy direction word only for selectors 5 to 7
   assign sub_hit = (op_field == `SST_OP_SUB);
   assign swap_hit = (op_field == `SST_OP_SWAP);
   assign dir_hit = (dir_field == `SST_OP_DIR) && (sel_field >= `SST_DIR_MIN);

   // Opcode classification, nothing without a valid word
   always_comb begin
      op = SST_NONE;
      if (instr_valid) begin
         if (sub_hit) begin
            op = SST_SUB;
         end else if (swap_hit) begin
            op = SST_SWAP;
         end else if (dir_hit) begin
            op = SST_DIR;
         end
      end
   end

   // Working register written only by subtract or swap with d clear
   assign w_write = (op == SST_SUB || op == SST_SWAP) && !dest;

   // ----------------------------------------
   // Arithmetic
   // ----------------------------------------
   // Borrow visible as the top bit; carry is its inverse
   assign diff = {1'b0, file_rdata} - {1'b0, work_reg};
   // Low-nibble borrow feeds digit carry
   assign low_diff = {1'b0, file_rdata[3:0]} - {1'b0, work_reg[3:0]};
   // Result selection
   always_comb begin
      unique case (op)
         SST_SUB: result = diff[7:0];
         SST_SWAP: result = {file_rdata[3:0], file_rdata[7:4]};
         SST_DIR: result = work_reg;
         SST_NONE: result = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Working register
   // ----------------------------------------
   // Updated at the end of the instruction cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         work_reg <= `SST_W_RESET;
      end else if (w_write) begin
         work_reg <= result;
      end
   end

   // ----------------------------------------
   // Write-back and flags
   // ----------------------------------------
   // Registered write-back toward the file and direction registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb <= '0;
      end else begin
         wb.w_we <= w_write;
         wb.f_we <= (op == SST_SUB || op == SST_SWAP) && dest;
         wb.f_addr <= addr_field;
         wb.dir_we <= (op == SST_DIR);
         wb.dir_sel <= sel_field;
         wb.data <= result;
      end
   end

   // Flags change only for subtract
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags <= '0;
      end else begin
         flags.we <= (op == SST_SUB);
         if (op == SST_SUB) begin
            flags.carry <= ~diff[8];
            flags.digit_carry_flag <= ~low_diff[4];
            flags.zero <= (diff[7:0] == 8'h00);
         end
      end
   end

   // ----------------------------------------
   // Subtract checks
   // ----------------------------------------
   // Subtract into the working register
   a_sub_dest_w: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB && !dest) |=> (work_reg == $past(diff[7:0]) && !wb.f_we))
      else $error("subtract to working register wrong");

   // Subtract back into the file register
   a_sub_dest_f: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB && dest) |=> (wb.f_we && $stable(work_reg) && wb.data == $past(diff[7:0])))
      else $error("subtract to file wrong");

   // File address carried with the write-back
   a_file_addr: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB || op == SST_SWAP) |=> (wb.f_addr == $past(instr[6:0])))
      else $error("file address wrong");

   // Any valid subtract word updates the flags, taken from the raw bits
   a_sub_decode: assert property (@(posedge clk) disable iff (!resetn)
      (instr_valid && instr[13:8] == `SST_OP_SUB) |=> flags.we)
      else $error("subtract not decoded");

   // Carry is the inverse of a borrow out of bit 7
   a_sub_carry: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB) |=> (flags.carry == ($past(file_rdata) >= $past(work_reg))))
      else $error("carry flag wrong");

   // Zero from the full 8-bit result
   a_sub_zero: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB) |=> (flags.zero == ($past(file_rdata) == $past(work_reg))))
      else $error("zero flag wrong");

   // Digit carry is the inverse of a low-nibble borrow
   a_sub_digit: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SUB) |=>
      (flags.digit_carry_flag == ($past(file_rdata[3:0]) >= $past(work_reg[3:0]))))
      else $error("digit carry wrong");

   // ----------------------------------------
   // Swap checks
   // ----------------------------------------
   // Swap exchanges nibbles and leaves the flags alone
   a_swap_value: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SWAP) |=>
      (wb.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !flags.we))
      else $error("swap result wrong");

   // Swap destination follows d
   a_swap_dest: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SWAP) |=> (wb.f_we == $past(dest) && wb.w_we == !$past(dest)))
      else $error("swap destination wrong");

   // Swap into W lands the exchanged value
   a_swap_to_w: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_SWAP && !dest) |=>
      (work_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}))
      else $error("swap into working register wrong");

   // ----------------------------------------
   // Direction checks
   // ----------------------------------------
   // Direction load copies W and touches no flag
   a_dir_load: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_DIR) |=>
      (wb.dir_we && wb.data == $past(work_reg) && $stable(work_reg) && !flags.we))
      else $error("direction load wrong");

   // Selector carried with the direction strobe
   a_dir_select: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_DIR) |=> (wb.dir_sel == $past(instr[2:0]) && wb.dir_sel >= `SST_DIR_MIN))
      else $error("direction selector wrong");

   // Direction words with selectors below 5 do nothing
   a_dir_refused: assert property (@(posedge clk) disable iff (!resetn)
      (instr_valid && instr[13:3] == `SST_OP_DIR && instr[2:0] < `SST_DIR_MIN) |=>
      (!wb.dir_we && !flags.we && $stable(work_reg)))
      else $error("refused direction word acted");

   // ----------------------------------------
   // Hold checks
   // ----------------------------------------
   // Flag values hold outside subtract
   a_flags_hold: assert property (@(posedge clk) disable iff (!resetn)
      (op != SST_SUB) |=>
      (!flags.we && $stable({flags.carry, flags.digit_carry_flag, flags.zero})))
      else $error("flags changed outside subtract");

   // W untouched unless a subtract or swap targets it
   a_w_hold: assert property (@(posedge clk) disable iff (!resetn)
      !w_write |=> $stable(work_reg))
      else $error("working register changed");

   // Nothing strobes without a decoded word
   a_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
      (op == SST_NONE) |=> (!wb.w_we && !wb.f_we && !wb.dir_we && !flags.we))
      else $error("spurious write-back");
endmodule // sst_exec

// *** bench/sst_file_model.sv ***
`timescale 1ns/10ps
module sst_file_model
   import sst_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [13:0] instr,
   input sst_wb_t wb,
   output logic [7:0] file_rdata
);
   logic [7:0] mem_ff [128];
   // File write-back; each cell resets to its own address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 128; i++) begin
            mem_ff[i] <= 8'(i);
         end
      end else if (wb.f_we) begin
         mem_ff[wb.f_addr] <= wb.data;
      end
   end
   // Read port follows the address field
   assign file_rdata = mem_ff[instr[6:0]];
endmodule // sst_file_model

// *** bench/subtract_swap_load_direction_register_exec_tb.sv ***
`timescale 1ns/10ps
module subtract_swap_load_direction_register_exec_tb;
   import sst_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [7:0] file_rdata;
   logic [7:0] work_reg;
   sst_wb_t wb;
   sst_flags_t flags;
   int fail_count = 0;
   int comparisons = 0;
   always #2.5 clk = ~clk;
   sst_exec i_sst_exec(.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
      .file_rdata(file_rdata), .work_reg(work_reg), .wb(wb), .flags(flags));
   sst_file_model i_sst_file_model(.clk(clk), .resetn(resetn), .instr(instr), .wb(wb),
      .file_rdata(file_rdata));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // One instruction, then W and data, strobes and flags in port order
   task step(input logic [13:0] op, input logic [15:0] regs, input logic [6:0] strb);
      @(negedge clk);
      instr_valid = 1'b1;
      instr = op;
      @(negedge clk);
      instr_valid = 1'b0;
      chk({work_reg, wb.data}, regs);
      chk({9'h000, wb.w_we, wb.f_we, wb.dir_we, flags}, {9'h000, strb});
   endtask
   // Swap into W, then into the file
   task t_swap;
      step(14'h0e20, 16'h0202, 7'h40);
      step(14'h0ebc, 16'h02c3, 7'h20);
      chk({9'h000, wb.f_addr}, 16'h003c);
   endtask
   // Positive, zero and negative differences
   task t_sub;
      step(14'h0283, 16'h0201, 7'h2e);
      chk({9'h000, wb.f_addr}, 16'h0003);
      step(14'h0282, 16'h0200, 7'h2f);
      step(14'h0201, 16'hffff, 7'h48);
      step(14'h020f, 16'h1010, 7'h4a);
   endtask
   // Direction load at both selector ends, refused selectors, foreign opcode
   task t_dir;
      step(14'h0066, 16'h1010, 7'h12);
      chk({13'h0000, wb.dir_sel}, 16'h0006);
      step(14'h0064, 16'h1000, 7'h02);
      step(14'h0065, 16'h1010, 7'h12);
      chk({13'h0000, wb.dir_sel}, 16'h0005);
      step(14'h0067, 16'h1010, 7'h12);
      chk({13'h0000, wb.dir_sel}, 16'h0007);
      step(14'h0063, 16'h1000, 7'h02);
      step(14'h0683, 16'h1000, 7'h02);
   endtask
   // Swap then subtract in consecutive cycles, the second using the new W
   task t_back;
      @(negedge clk);
      instr_valid = 1'b1;
      instr = 14'h0e0f;
      @(negedge clk);
      instr = 14'h0281;
      chk({work_reg, wb.data}, 16'hf0f0);
      @(negedge clk);
      instr_valid = 1'b0;
      chk({work_reg, wb.data}, 16'hf011);
      chk({9'h000, wb.w_we, wb.f_we, wb.dir_we, flags}, 16'h002a);
   endtask
   // Reset in mid-run clears every output, then a first subtract
   task t_reset;
      @(negedge clk);
      resetn = 1'b0;
      @(negedge clk);
      chk({work_reg, wb.data}, 16'h0000);
      chk({9'h000, wb.w_we, wb.f_we, wb.dir_we, flags}, 16'h0000);
      chk({6'h00, wb.f_addr, wb.dir_sel}, 16'h0000);
      resetn = 1'b1;
      step(14'h0283, 16'h0003, 7'h2e);
   endtask
   task close_out;
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Reset, then scenarios
   initial begin
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      t_swap();
      t_sub();
      t_dir();
      t_back();
      t_reset();
      close_out();
   end
endmodule // subtract_swap_load_direction_register_exec_tb
